// [shared/result_port_cfg.svh]
// register map, field positions, reset values and limits of the parallel result port
`ifndef RESULT_PORT_CFG_SVH
`define RESULT_PORT_CFG_SVH

`define REG_CTRL        8'h00
`define REG_OR_INCLUDE  8'h04
`define REG_JUDGE_POL   8'h08
`define REG_EXPR_COUNT  8'h0c
`define REG_STB_DELAY   8'h10
`define REG_STB_ON      8'h14
`define REG_OUT_CYCLE   8'h18
`define REG_STATUS      8'h1c

`define CTRL_RUN        0
`define CTRL_DATA_DEST  1
`define CTRL_JUDGE_DEST 2
`define CTRL_OR_ON_NG   3

`define CAT_W           5
`define CAT_JUDGE       3
`define CNT_FIELD_W     6
`define JCNT_LSB        8
`define MAX_EXPR        6'h20
`define HALF_EXPR       6'h10
`define MAX_WORDS       35

`define TIME_W          24
`define RST_STB_DELAY   24'h0003e8
`define RST_STB_ON      24'h001388
`define RST_OUT_CYCLE   24'h002710
`define RST_JUDGE_POL   32'hffffffff
`define RST_OR_INCLUDE  5'h1f

`define ENT_HAS_WORD    18
`define ENT_LAST        17
`define ENT_OR          16
`define ENT_W           19

`define STAT_LEVEL_LSB  8
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// [shared/result_port_pkg.sv]
// state types of the parallel result port
`default_nettype none
package result_port_pkg;
	typedef enum logic [2:0] {MS_IDLE, MS_MEAS, MS_JUDGE_LO, MS_JUDGE_HI, MS_FINAL} meas_state_t;
	typedef enum logic [0:0] {OS_IDLE, OS_CYCLE} out_state_t;
endpackage
`default_nettype wire

// [rtl/value_round_sat.sv]
// rounds a fixed-point measurement to an integer and saturates it to 16 bits
`timescale 1ns/100ps
`default_nettype none
module value_round_sat #(
	parameter int IN_W   = 32,
	parameter int FRAC_W = 8
)(
	input  wire logic signed [IN_W-1:0] value_i,
	output logic signed [15:0]          word_o
);
	logic signed [IN_W:0] wide;
	logic signed [IN_W:0] rounded;

	// half-up rounding; one extra bit keeps the add from wrapping
	always_comb begin
		wide    = (IN_W+1)'(value_i) + (IN_W+1)'(1 <<< (FRAC_W - 1));
		rounded = wide >>> FRAC_W;
		if (rounded < -(IN_W+1)'(32768)) begin
			word_o = 16'sh8000;
		end else if (rounded > (IN_W+1)'(32767)) begin
			word_o = 16'sh7fff;
		end else begin
			word_o = rounded[15:0];
		end
	end
endmodule
`default_nettype wire

// [rtl/word_queue.sv]
// flip-flop queue of pending output entries
`timescale 1ns/100ps
`default_nettype none
module word_queue #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 64,
	localparam int AW   = $clog2(DEPTH),
	localparam int CW   = $clog2(DEPTH + 1)
)(
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             push_i,
	input  wire logic [WIDTH-1:0] data_i,
	input  wire logic             pop_i,
	output logic      [WIDTH-1:0] data_o,
	output logic                  empty_o,
	output logic                  full_o,
	output logic      [CW-1:0]    level_o
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             do_push;
	logic             do_pop;

	assign do_push = push_i && !full_o;
	assign do_pop  = pop_i && !empty_o;
	assign data_o  = mem[rd_ptr];
	assign empty_o = (level_o == '0);
	assign full_o  = (level_o == CW'(DEPTH));

	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem[wr_ptr] <= data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr  <= '0;
			rd_ptr  <= '0;
			level_o <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (do_push && !do_pop) begin
				level_o <= level_o + 1'b1;
			end else if (do_pop && !do_push) begin
				level_o <= level_o - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/parallel_result_output.sv]
// parallel result port: trigger, result queue, word sequencer with strobe, axi4-lite registers
`timescale 1ns/100ps
`default_nettype none
`include "result_port_cfg.svh"
module parallel_result_output #(
	parameter int VALUE_W     = 32,
	parameter int FRAC_W      = 8,
	parameter int QUEUE_DEPTH = 64
)(
	input  wire logic               SYS_CLK_I,
	input  wire logic               RESET_N_I,
	input  wire logic [7:0]         S_AXI_AWADDR_I,
	input  wire logic               S_AXI_AWVALID_I,
	output logic                    S_AXI_AWREADY_O,
	input  wire logic [31:0]        S_AXI_WDATA_I,
	input  wire logic [3:0]         S_AXI_WSTRB_I,
	input  wire logic               S_AXI_WVALID_I,
	output logic                    S_AXI_WREADY_O,
	output logic [1:0]              S_AXI_BRESP_O,
	output logic                    S_AXI_BVALID_O,
	input  wire logic               S_AXI_BREADY_I,
	input  wire logic [7:0]         S_AXI_ARADDR_I,
	input  wire logic               S_AXI_ARVALID_I,
	output logic                    S_AXI_ARREADY_O,
	output logic [31:0]             S_AXI_RDATA_O,
	output logic [1:0]              S_AXI_RRESP_O,
	output logic                    S_AXI_RVALID_O,
	input  wire logic               S_AXI_RREADY_I,
	input  wire logic               TRIG_I,
	output logic                    ENABLE_O,
	output logic                    MEAS_START_O,
	input  wire logic               MEAS_VALUE_VALID_I,
	input  wire logic [VALUE_W-1:0] MEAS_VALUE_I,
	input  wire logic               MEAS_DONE_I,
	input  wire logic [`CAT_W-1:0]  MEAS_CAT_NG_I,
	input  wire logic [31:0]        MEAS_JUDGE_NG_I,
	output logic [15:0]             RESULT_WORD_O,
	output logic                    STROBE_O,
	output logic                    OVERALL_JUDGE_O
);
	localparam int CW = $clog2(QUEUE_DEPTH + 1);

	////////////////////////////////////////////////////////////////////////////////
	// configuration
	logic                    run_mode;
	logic                    data_dest;
	logic                    judge_dest;
	logic                    or_on_ng;
	logic [`CAT_W-1:0]       or_include;
	logic [31:0]             judge_pol;
	logic [`CNT_FIELD_W-1:0] data_count;
	logic [`CNT_FIELD_W-1:0] judge_count;
	logic [`TIME_W-1:0]      stb_delay;
	logic [`TIME_W-1:0]      stb_on;
	logic [`TIME_W-1:0]      out_cycle;

	// bus
	logic        aw_have;
	logic        w_have;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	logic        wr_ok;
	logic [31:0] rd_data;
	logic        rd_ok;
	logic [31:0] old_val;
	logic [31:0] merged;

	// measurement and queue
	result_port_pkg::meas_state_t meas_state;
	result_port_pkg::out_state_t  out_state;
	logic                    trig_meta;
	logic                    trig_sync;
	logic                    trig_prev;
	logic                    room;
	logic                    accept;
	logic [`CNT_FIELD_W-1:0] values_taken;
	logic [31:0]             expr_mask;
	logic [32:0]             mask_wide;
	logic [31:0]             judge_bits;
	logic                    or_level;
	logic [1:0]              judge_words;
	logic                    any_ng;
	logic [`CAT_W-1:0]       cat_ng;
	logic signed [15:0]      value_word;
	logic                    push;
	logic [`ENT_W-1:0]       entry;
	logic [`ENT_W-1:0]       head;
	logic                    q_empty;
	logic [CW-1:0]           q_level;
	logic                    pop;
	logic [`TIME_W-1:0]      cnt;
	logic [`TIME_W-1:0]      next_cnt;

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave, one write and one read in flight
	assign do_write = aw_have && w_have && !S_AXI_BVALID_O;

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			aw_have         <= 1'b0;
			w_have          <= 1'b0;
			aw_addr         <= '0;
			w_data          <= '0;
			w_strb          <= '0;
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O  <= 1'b0;
			S_AXI_BVALID_O  <= 1'b0;
			S_AXI_BRESP_O   <= `RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
				aw_have <= 1'b1;
				aw_addr <= S_AXI_AWADDR_I;
			end else if (do_write) begin
				aw_have <= 1'b0;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
				w_have <= 1'b1;
				w_data <= S_AXI_WDATA_I;
				w_strb <= S_AXI_WSTRB_I;
			end else if (do_write) begin
				w_have <= 1'b0;
			end
			S_AXI_AWREADY_O <= !aw_have && !S_AXI_AWREADY_O && !S_AXI_BVALID_O;
			S_AXI_WREADY_O  <= !w_have && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
			if (do_write) begin
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (S_AXI_BREADY_I) begin
				S_AXI_BVALID_O <= 1'b0;
			end
		end
	end

	// read decode; a second decode on the write address gives the old value for byte-lane merging
	always_comb begin
		rd_ok   = 1'b1;
		rd_data = '0;
		if (S_AXI_ARADDR_I == `REG_CTRL) begin
			rd_data[`CTRL_RUN]        = run_mode;
			rd_data[`CTRL_DATA_DEST]  = data_dest;
			rd_data[`CTRL_JUDGE_DEST] = judge_dest;
			rd_data[`CTRL_OR_ON_NG]   = or_on_ng;
		end else if (S_AXI_ARADDR_I == `REG_OR_INCLUDE) begin
			rd_data[`CAT_W-1:0] = or_include;
		end else if (S_AXI_ARADDR_I == `REG_JUDGE_POL) begin
			rd_data = judge_pol;
		end else if (S_AXI_ARADDR_I == `REG_EXPR_COUNT) begin
			rd_data[`CNT_FIELD_W-1:0]                  = data_count;
			rd_data[`JCNT_LSB +: `CNT_FIELD_W]         = judge_count;
		end else if (S_AXI_ARADDR_I == `REG_STB_DELAY) begin
			rd_data[`TIME_W-1:0] = stb_delay;
		end else if (S_AXI_ARADDR_I == `REG_STB_ON) begin
			rd_data[`TIME_W-1:0] = stb_on;
		end else if (S_AXI_ARADDR_I == `REG_OUT_CYCLE) begin
			rd_data[`TIME_W-1:0] = out_cycle;
		end else if (S_AXI_ARADDR_I == `REG_STATUS) begin
			rd_data[0]                     = (meas_state != result_port_pkg::MS_IDLE);
			rd_data[1]                     = (out_state != result_port_pkg::OS_IDLE) || !q_empty;
			rd_data[2]                     = !room;
			rd_data[3]                     = ENABLE_O;
			rd_data[`STAT_LEVEL_LSB +: CW] = q_level;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_comb begin
		wr_ok   = 1'b1;
		old_val = '0;
		if (aw_addr == `REG_CTRL) begin
			old_val[3:0] = {or_on_ng, judge_dest, data_dest, run_mode};
		end else if (aw_addr == `REG_OR_INCLUDE) begin
			old_val[`CAT_W-1:0] = or_include;
		end else if (aw_addr == `REG_JUDGE_POL) begin
			old_val = judge_pol;
		end else if (aw_addr == `REG_EXPR_COUNT) begin
			old_val[`CNT_FIELD_W-1:0]          = data_count;
			old_val[`JCNT_LSB +: `CNT_FIELD_W] = judge_count;
		end else if (aw_addr == `REG_STB_DELAY) begin
			old_val[`TIME_W-1:0] = stb_delay;
		end else if (aw_addr == `REG_STB_ON) begin
			old_val[`TIME_W-1:0] = stb_on;
		end else if (aw_addr == `REG_OUT_CYCLE) begin
			old_val[`TIME_W-1:0] = out_cycle;
		end else if (aw_addr != `REG_STATUS) begin
			wr_ok = 1'b0;
		end
		for (int b = 0; b < 4; b++) begin
			merged[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : old_val[b*8 +: 8];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O  <= 1'b0;
			S_AXI_RDATA_O   <= '0;
			S_AXI_RRESP_O   <= `RESP_OKAY;
		end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O  <= 1'b1;
			S_AXI_RDATA_O   <= rd_data;
			S_AXI_RRESP_O   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O  <= 1'b0;
		end
	end

	// expression counts above 32 are clamped on write
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			{or_on_ng, judge_dest, data_dest, run_mode} <= 4'h0;
			or_include  <= `RST_OR_INCLUDE;
			judge_pol   <= `RST_JUDGE_POL;
			data_count  <= '0;
			judge_count <= '0;
			stb_delay   <= `RST_STB_DELAY;
			stb_on      <= `RST_STB_ON;
			out_cycle   <= `RST_OUT_CYCLE;
		end else if (do_write) begin
			if (aw_addr == `REG_CTRL) begin
				{or_on_ng, judge_dest, data_dest, run_mode} <= merged[3:0];
			end else if (aw_addr == `REG_OR_INCLUDE) begin
				or_include <= merged[`CAT_W-1:0];
			end else if (aw_addr == `REG_JUDGE_POL) begin
				judge_pol <= merged;
			end else if (aw_addr == `REG_EXPR_COUNT) begin
				data_count  <= (merged[7:0] >= {2'h0, `MAX_EXPR}) ? `MAX_EXPR : merged[5:0];
				judge_count <= (merged[15:8] >= {2'h0, `MAX_EXPR}) ? `MAX_EXPR : merged[13:8];
			end else if (aw_addr == `REG_STB_DELAY) begin
				stb_delay <= merged[`TIME_W-1:0];
			end else if (aw_addr == `REG_STB_ON) begin
				stb_on <= merged[`TIME_W-1:0];
			end else if (aw_addr == `REG_OUT_CYCLE) begin
				out_cycle <= merged[`TIME_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// trigger and measurement capture
	// worst case entries per measurement must fit before a trigger is taken
	assign room   = (q_level <= CW'(QUEUE_DEPTH - `MAX_WORDS));
	assign accept = trig_sync && !trig_prev && run_mode && room &&
		(meas_state == result_port_pkg::MS_IDLE);

	assign mask_wide = (33'h1 << judge_count) - 33'h1;
	assign expr_mask = mask_wide[31:0];
	assign cat_ng    = MEAS_CAT_NG_I | (`CAT_W'(|(MEAS_JUDGE_NG_I & expr_mask)) << `CAT_JUDGE);
	assign any_ng    = |(cat_ng & or_include);

	value_round_sat #(
		.IN_W   (VALUE_W),
		.FRAC_W (FRAC_W)
	) u_round (
		.value_i (MEAS_VALUE_I),
		.word_o  (value_word)
	);

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			trig_meta <= 1'b0;
			trig_sync <= 1'b0;
			trig_prev <= 1'b0;
		end else begin
			trig_meta <= TRIG_I;
			trig_sync <= trig_meta;
			trig_prev <= trig_sync;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			meas_state   <= result_port_pkg::MS_IDLE;
			MEAS_START_O <= 1'b0;
			ENABLE_O     <= 1'b0;
			values_taken <= '0;
			judge_bits   <= '0;
			or_level     <= 1'b0;
			judge_words  <= 2'h0;
		end else begin
			MEAS_START_O <= accept;
			ENABLE_O     <= run_mode && room && (meas_state == result_port_pkg::MS_IDLE) && !accept;
			if (push && meas_state == result_port_pkg::MS_MEAS) begin
				values_taken <= values_taken + 1'b1;
			end
			case (meas_state)
				result_port_pkg::MS_IDLE: begin
					values_taken <= '0;
					if (accept) begin
						meas_state <= result_port_pkg::MS_MEAS;
					end
				end
				result_port_pkg::MS_MEAS: begin
					if (MEAS_DONE_I) begin
						judge_bits <= ~(MEAS_JUDGE_NG_I ^ judge_pol) & expr_mask;
						or_level   <= or_on_ng ? any_ng : !any_ng;
						if (!judge_dest || judge_count == '0) begin
							judge_words <= 2'h0;
							meas_state  <= result_port_pkg::MS_FINAL;
						end else begin
							judge_words <= (judge_count > `HALF_EXPR) ? 2'h2 : 2'h1;
							meas_state  <= result_port_pkg::MS_JUDGE_LO;
						end
					end
				end
				result_port_pkg::MS_JUDGE_LO: begin
					meas_state <= (judge_words == 2'h2) ? result_port_pkg::MS_JUDGE_HI
						: result_port_pkg::MS_IDLE;
				end
				default: begin
					meas_state <= result_port_pkg::MS_IDLE;
				end
			endcase
		end
	end

	// values enter during the measurement, judgments after it, so values lead
	always_comb begin
		push  = 1'b0;
		entry = '0;
		case (meas_state)
			result_port_pkg::MS_MEAS: begin
				push  = MEAS_VALUE_VALID_I && data_dest && (values_taken < data_count);
				entry = {1'b1, 1'b0, 1'b0, value_word};
			end
			result_port_pkg::MS_JUDGE_LO: begin
				push  = 1'b1;
				entry = {1'b1, judge_words == 2'h1, or_level, judge_bits[15:0]};
			end
			result_port_pkg::MS_JUDGE_HI: begin
				push  = 1'b1;
				entry = {1'b1, 1'b1, or_level, judge_bits[31:16]};
			end
			result_port_pkg::MS_FINAL: begin
				push  = 1'b1;
				entry = {1'b0, 1'b1, or_level, 16'h0000};
			end
			default: begin
				push = 1'b0;
			end
		endcase
	end

	word_queue #(
		.WIDTH (`ENT_W),
		.DEPTH (QUEUE_DEPTH)
	) u_queue (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RESET_N_I),
		.push_i  (push),
		.data_i  (entry),
		.pop_i   (pop),
		.data_o  (head),
		.empty_o (q_empty),
		.full_o  (),
		.level_o (q_level)
	);

	////////////////////////////////////////////////////////////////////////////////
	// output sequencer; pending words wait in the queue while not in run mode
	assign pop      = (out_state == result_port_pkg::OS_IDLE) && !q_empty && run_mode;
	assign next_cnt = cnt + 1'b1;

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			out_state       <= result_port_pkg::OS_IDLE;
			cnt             <= '0;
			RESULT_WORD_O   <= '0;
			OVERALL_JUDGE_O <= 1'b0;
			STROBE_O        <= 1'b0;
		end else begin
			case (out_state)
				result_port_pkg::OS_IDLE: begin
					STROBE_O <= 1'b0;
					if (pop) begin
						if (head[`ENT_LAST]) begin
							OVERALL_JUDGE_O <= head[`ENT_OR];
						end
						// an entry without a word only moves the overall line
						if (head[`ENT_HAS_WORD]) begin
							RESULT_WORD_O <= head[15:0];
							cnt           <= '0;
							out_state     <= result_port_pkg::OS_CYCLE;
						end
					end
				end
				default: begin
					cnt <= next_cnt;
					// strobe never reaches the last cycle, so it falls before the word moves
					STROBE_O <= (next_cnt >= stb_delay) && (next_cnt - stb_delay < stb_on) &&
						(next_cnt + 1'b1 < out_cycle);
					if (next_cnt + 1'b1 >= out_cycle) begin
						out_state <= result_port_pkg::OS_IDLE;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// [tb/result_port_checker_sva.sv]
// concurrent checks on the parallel result port pins and its register bus handshake
`timescale 1ns/100ps
`default_nettype none
module result_port_checker (
	input wire logic        SYS_CLK_I,
	input wire logic        RESET_N_I,
	input wire logic        S_AXI_AWVALID_I,
	input wire logic        S_AXI_AWREADY_O,
	input wire logic        S_AXI_WVALID_I,
	input wire logic        S_AXI_WREADY_O,
	input wire logic [1:0]  S_AXI_BRESP_O,
	input wire logic        S_AXI_BVALID_O,
	input wire logic        S_AXI_BREADY_I,
	input wire logic        S_AXI_ARVALID_I,
	input wire logic        S_AXI_ARREADY_O,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic        S_AXI_RVALID_O,
	input wire logic        S_AXI_RREADY_I,
	input wire logic        TRIG_I,
	input wire logic        ENABLE_O,
	input wire logic        MEAS_START_O,
	input wire logic [15:0] RESULT_WORD_O,
	input wire logic        STROBE_O
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	AST_WORD_STEADY: assert property ($changed(RESULT_WORD_O) |-> !STROBE_O)
		else $error("result word moved while strobe high");
	AST_START_PULSE: assert property (MEAS_START_O |=> !MEAS_START_O [*4])
		else $error("measurement start repeated");
	AST_START_ENABLED: assert property (MEAS_START_O |-> $past(ENABLE_O) || $past(ENABLE_O, 2))
		else $error("measurement started while not enabled");
	AST_START_TRIG: assert property (MEAS_START_O |-> $past(TRIG_I, 3))
		else $error("measurement started without trigger");
	AST_B_HOLD: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
		|=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
		|=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("read data dropped early");
	AST_R_ANSWER: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
		else $error("read answer late");
	AST_B_ANSWER: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
		&& S_AXI_WREADY_O |=> ##1 S_AXI_BVALID_O)
		else $error("write answer late");
	AST_AW_REFUSE: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
		else $error("write taken during pending response");
endmodule
bind parallel_result_output result_port_checker checker_u (
	.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
	.S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
	.S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
	.S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
	.S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
	.S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
	.S_AXI_RREADY_I(S_AXI_RREADY_I), .TRIG_I(TRIG_I), .ENABLE_O(ENABLE_O),
	.MEAS_START_O(MEAS_START_O), .RESULT_WORD_O(RESULT_WORD_O), .STROBE_O(STROBE_O));
`default_nettype wire

// [tb/result_reader_model.sv]
// external controller: drives the trigger pin and samples result words under strobe
`timescale 1ns/100ps
`default_nettype none
module result_reader_model #(
	parameter int TRIG_HOLD = 25000
)(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        trig_req_i,
	input wire logic [15:0] word_i,
	input wire logic        strobe_i,
	output logic            trig_o,
	output logic [15:0]     cap_word_o,
	output logic            cap_valid_o
);
	int   hold;
	logic strobe_d;
	// 0.5 ms at 50 MHz; a new request is ignored until the pin is low again
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			trig_o <= 1'b0;
			hold <= 0;
		end else if (trig_req_i && !trig_o) begin
			trig_o <= 1'b1;
			hold <= TRIG_HOLD;
		end else if (hold > 1) begin
			hold <= hold - 1;
		end else begin
			trig_o <= 1'b0;
			hold <= 0;
		end
	end
	// word is taken only once strobe has risen, never at the word change
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strobe_d <= 1'b0;
			cap_valid_o <= 1'b0;
			cap_word_o <= 16'h0000;
		end else begin
			strobe_d <= strobe_i;
			cap_valid_o <= strobe_i && !strobe_d;
			cap_word_o <= word_i;
		end
	end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// bench for the parallel result port: register bus, trigger, engine feed, word capture
`timescale 1ns/100ps
`default_nettype none
`include "result_port_cfg.svh"
module tb_top;
	logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, trig_req, mvalid, mdone;
	logic        awready, wready, bvalid, arready, rvalid, trig, enable, mstart, strobe;
	logic        overall, cap_valid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, mvalue, mjudge, rdata;
	logic [4:0]  mcat;
	logic [1:0]  bresp, rresp;
	logic [15:0] word, cap_word;
	logic [15:0] got[$];
	int          fails, comparisons, starts, stb_cycles;
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	parallel_result_output dut_u (
		.SYS_CLK_I(clk), .RESET_N_I(rst_n), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
		.S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf),
		.S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
		.S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
		.S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
		.S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
		.TRIG_I(trig), .ENABLE_O(enable), .MEAS_START_O(mstart), .MEAS_VALUE_VALID_I(mvalid),
		.MEAS_VALUE_I(mvalue), .MEAS_DONE_I(mdone), .MEAS_CAT_NG_I(mcat),
		.MEAS_JUDGE_NG_I(mjudge), .RESULT_WORD_O(word), .STROBE_O(strobe),
		.OVERALL_JUDGE_O(overall));
	result_reader_model #(.TRIG_HOLD(25000)) reader_u (
		.clk_i(clk), .rst_n_i(rst_n), .trig_req_i(trig_req), .word_i(word), .strobe_i(strobe),
		.trig_o(trig), .cap_word_o(cap_word), .cap_valid_o(cap_valid));
	always @(posedge clk) begin
		if (cap_valid)
			got.push_back(cap_word);
		if (mstart)
			starts++;
		if (strobe)
			stb_cycles++;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic give_up();
		fails++;
		report_and_stop();
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 200; n++) begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				check(bresp, er);
				return;
			end
		end
		give_up();
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 200; n++) begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				check(rdata, exp);
				check(rresp, er);
				return;
			end
		end
		give_up();
	endtask
	task automatic fire();
		@(posedge clk);
		trig_req <= 1'b1;
		@(posedge clk);
		trig_req <= 1'b0;
	endtask
	task automatic wait_start();
		for (int n = 0; n < 100; n++) begin
			@(posedge clk);
			if (mstart)
				return;
		end
		give_up();
	endtask
	// next trigger only after the pin has dropped, well past the total output time
	task automatic trig_quiet();
		for (int n = 0; n < 30000; n++) begin
			@(posedge clk);
			if (!trig)
				return;
		end
		give_up();
	endtask
	task automatic send(input logic [31:0] v);
		@(posedge clk);
		mvalue <= v;
		mvalid <= 1'b1;
		@(posedge clk);
		mvalid <= 1'b0;
	endtask
	task automatic finish_meas(input logic [4:0] cat, input logic [31:0] ng);
		@(posedge clk);
		mcat <= cat;
		mjudge <= ng;
		mdone <= 1'b1;
		@(posedge clk);
		mdone <= 1'b0;
	endtask
	task automatic wait_words(input int cnt);
		for (int n = 0; n < 2000; n++) begin
			@(posedge clk);
			if (got.size() >= cnt)
				return;
		end
		give_up();
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, trig_req, mvalid, mdone} = 9'h000;
		{awaddr, araddr, wdata, mvalue, mjudge, mcat} = 117'h0;
		fails = 0;
		comparisons = 0;
		starts = 0;
		stb_cycles = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		axi_rd(`REG_STB_DELAY, {8'h00, `RST_STB_DELAY}, `RESP_OKAY);
		axi_rd(`REG_OUT_CYCLE, {8'h00, `RST_OUT_CYCLE}, `RESP_OKAY);
		axi_rd(`REG_JUDGE_POL, `RST_JUDGE_POL, `RESP_OKAY);
		axi_rd(8'h40, 32'h0, `RESP_SLVERR);
		axi_wr(8'h44, 32'h1, `RESP_SLVERR);
		axi_wr(`REG_STB_DELAY, 32'h2, `RESP_OKAY);
		axi_wr(`REG_STB_ON, 32'h3, `RESP_OKAY);
		axi_wr(`REG_OUT_CYCLE, 32'h8, `RESP_OKAY);
		axi_wr(`REG_EXPR_COUNT, 32'h0000_ff20, `RESP_OKAY);
		axi_rd(`REG_EXPR_COUNT, 32'h0000_2020, `RESP_OKAY);
		axi_wr(`REG_EXPR_COUNT, 32'h0000_1102, `RESP_OKAY);
		axi_wr(`REG_CTRL, 32'h0000_000f, `RESP_OKAY);
		fire();
		wait_start();
		send(32'h0004_d280);
		send(32'h00ff_0000);
		send(32'h0000_0100);
		finish_meas(5'h00, 32'h0001_8001);
		wait_words(4);
		check(got[0], 32'h04d3);
		check(got[1], 32'h7fff);
		check(got[2], 32'h8001);
		check(got[3], 32'h0001);
		check(overall, 32'h1);
		trig_quiet();
		check(enable, 32'h1);
		check(stb_cycles, 12);
		// adjustment mode: trigger must be ignored, enable drops and the word and overall pins hold
		axi_wr(`REG_CTRL, 32'h0000_000e, `RESP_OKAY);
		fire();
		trig_quiet();
		check(starts, 1);
		check(enable, 32'h0);
		check(got.size(), 4);
		check(word, 32'h0001);
		check(overall, 32'h1);
		axi_wr(`REG_OR_INCLUDE, 32'h0000_001d, `RESP_OKAY);
		axi_wr(`REG_CTRL, 32'h0000_000b, `RESP_OKAY);
		fire();
		wait_start();
		send(32'hff63_c000);
		send(32'hfffb_2d80);
		finish_meas(5'h02, 32'h0000_0000);
		wait_words(6);
		for (int n = 0; n < 100 && overall !== 1'b0; n++)
			@(posedge clk);
		repeat (16) @(posedge clk);
		check(overall, 32'h0);
		check(got[4], 32'h8000);
		check(got[5], 32'hfb2e);
		check(got.size(), 6);
		check(starts, 2);
		check(stb_cycles, 18);
		report_and_stop();
	end
endmodule
`default_nettype wire
